// ---- logic/i2cts_top.v ----
// I2C target port: registers, bus sequencer, flags and clock stretching
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "i2cts_consts.vh"

module i2cts_top (
  input  wire       clk,
  input  wire       reset_n,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_q,
  input  wire       global_irq_en,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        scl_out_q,
  output reg        scl_oe_q,
  output reg        sda_out_q,
  output reg        sda_oe_q,
  output reg        data_irq_q,
  output reg        addr_stop_irq_q
);

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  localparam [2:0] ST_IDLE    = 3'h0;  // Released, waiting for a Start
  localparam [2:0] ST_ADDR    = 3'h1;  // Shifting in the address byte
  localparam [2:0] ST_HOLD    = 3'h2;  // SCL stretched, software to act
  localparam [2:0] ST_ACK_OUT = 3'h3;  // Driving our acknowledge bit
  localparam [2:0] ST_RX      = 3'h4;  // Receiving a data byte
  localparam [2:0] ST_TX      = 3'h5;  // Sending a data byte
  localparam [2:0] ST_ACK_IN  = 3'h6;  // Sampling master acknowledge

  // Where to go once our acknowledge bit is done
  localparam [1:0] AFT_RX     = 2'h0;
  localparam [1:0] AFT_DIF    = 2'h1;
  localparam [1:0] AFT_IDLE   = 2'h2;

  // ----------------------------------------
  // Address decode helper
  // ----------------------------------------
  function sel;
    input [7:0] a;
    input [7:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  // ----------------------------------------
  // State and register storage
  // ----------------------------------------
  reg  [1:0] pin_s1_q;       // {sda, scl} first stage, feeds stage two only
  reg  [1:0] pin_s2_q;       // Second stage
  reg  [1:0] pin_s3_q;       // Third stage, compared with second
  reg  [1:0] filt_q;         // Accepted line levels
  reg  [1:0] filt_d;
  reg  [7:0] setup_q;        // Setup A register
  reg  [7:0] own_q;          // Own match value
  reg        ack_choice_q;   // Stored acknowledge choice
  reg        ack_choice_d;
  reg  [2:0] st_q;
  reg  [2:0] st_d;
  reg  [1:0] aft_q;
  reg  [1:0] aft_d;
  reg  [3:0] cnt_q;          // Bit counter within a byte
  reg  [3:0] cnt_d;
  reg  [7:0] shreg_q;        // Target shift register
  reg  [7:0] shreg_d;
  reg        hold_data_q;    // Hold caused by data (1) or address (0)
  reg        hold_data_d;
  reg        ack_send_q;     // Ack bit latched at resume, 1 = NACK
  reg        ack_send_d;
  reg        data_flag_q;
  reg        data_flag_d;
  reg        addr_stop_flag_q;
  reg        addr_stop_flag_d;
  reg        received_ack_bit_q;
  reg        received_ack_bit_d;
  reg        tx_clash_q;
  reg        tx_clash_d;
  reg        clash_act_q;    // Low drive disabled till operation ends
  reg        clash_act_d;
  reg        bus_fault_q;
  reg        bus_fault_d;
  reg        dir_q;
  reg        dir_d;
  reg        cause_select_q;
  reg        cause_select_d;
  reg        start_seen_q;   // Start seen, no SCL fall since
  reg        start_seen_d;
  reg  [7:0] rdata_d;

  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  wire       data_irq_en      = setup_q[`I2CTS_SA_DATA_IRQ_EN];
  wire       addr_stop_irq_en = setup_q[`I2CTS_SA_ADDR_STOP_IRQ_EN];
  wire       stop_flag_en     = setup_q[`I2CTS_SA_STOP_FLAG_EN];
  wire       promiscuous_match = setup_q[`I2CTS_SA_PROMISCUOUS_MATCH];
  wire       auto_continue_en = setup_q[`I2CTS_SA_AUTO_CONTINUE_EN];
  wire       port_en          = setup_q[`I2CTS_SA_EN];
  wire [1:0] slave_command    = reg_wdata[1:0];
  wire       cmd_wr     = reg_wr & sel(reg_addr, `I2CTS_OFS_COMMAND);
  wire       cmd_valid  = cmd_wr & slave_command[1];  // Codes 2 and 3 only
  wire       cmd_rsvd   = cmd_wr & (slave_command == `I2CTS_CMD_RSVD);
  wire       finish_transfer = cmd_valid & (slave_command == `I2CTS_CMD_FINISH);
  wire       data_acc   = (reg_wr | reg_rd) & sel(reg_addr, `I2CTS_OFS_DATA);
  wire       flags_wr   = reg_wr & sel(reg_addr, `I2CTS_OFS_FLAGS);
  wire       clr_common = cmd_valid | data_acc;
  wire       in_hold    = (st_q == ST_HOLD);
  wire       resume     = in_hold & (cmd_valid | (data_acc & auto_continue_en));
  wire       ack_eff    = cmd_valid ? reg_wdata[`I2CTS_CB_ACK] : ack_choice_q;

  // ----------------------------------------
  // Line edges and bus conditions
  // ----------------------------------------
  wire scl_rise = filt_d[0] & ~filt_q[0];
  wire scl_fall = ~filt_d[0] & filt_q[0];
  wire sda_now  = filt_d[1];
  wire bus_start = ~filt_d[1] & filt_q[1] & filt_q[0] & filt_d[0];
  wire bus_stop  = filt_d[1] & ~filt_q[1] & filt_q[0] & filt_d[0];
  wire in_byte   = (st_q == ST_ADDR) | (st_q == ST_RX) | (st_q == ST_TX);
  wire addr_hit  = promiscuous_match |
                   (shreg_q[7:1] == own_q[7:1]) |
                   (own_q[0] & (shreg_q[7:1] == `I2CTS_GCALL_ADDR));

  // ----------------------------------------
  // Pin filter: a level counts once stages two and three agree
  // ----------------------------------------
  always @* begin
    filt_d = (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (filt_q & (pin_s2_q ^ pin_s3_q));
  end

  // ----------------------------------------
  // Sequencer and flag next state
  // ----------------------------------------
  always @* begin
    st_d               = st_q;
    aft_d              = aft_q;
    cnt_d              = cnt_q;
    shreg_d            = shreg_q;
    hold_data_d        = hold_data_q;
    ack_send_d         = ack_send_q;
    received_ack_bit_d = received_ack_bit_q;
    clash_act_d        = clash_act_q;
    dir_d              = dir_q;
    cause_select_d     = cause_select_q;
    start_seen_d       = start_seen_q;
    // Flags: hardware set below wins over any clear
    data_flag_d      = data_flag_q & ~(clr_common | (flags_wr & reg_wdata[`I2CTS_FL_DIF]));
    addr_stop_flag_d = addr_stop_flag_q & ~(clr_common | (flags_wr & reg_wdata[`I2CTS_FL_ADDR_STOP_FLAG]));
    tx_clash_d       = tx_clash_q & ~((flags_wr & reg_wdata[`I2CTS_FL_TX_CLASH]) | bus_start);
    bus_fault_d      = bus_fault_q & ~(flags_wr & reg_wdata[`I2CTS_FL_BERR]);
    // Software may load data only while the clock is stretched
    if (in_hold & reg_wr & sel(reg_addr, `I2CTS_OFS_DATA)) begin
      shreg_d = reg_wdata;
    end
    if (scl_fall) begin
      start_seen_d = 1'b0;
    end
    case (st_q)
      ST_ADDR: begin
        if (scl_rise) begin
          shreg_d = {shreg_q[6:0], sda_now};
          cnt_d   = cnt_q + `I2CTS_CNT_ONE;
        end else if (scl_fall && cnt_q == `I2CTS_BYTE_BITS) begin
          cnt_d = `I2CTS_CNT_ZERO;
          if (addr_hit) begin
            addr_stop_flag_d = 1'b1;
            cause_select_d   = 1'b1;
            dir_d            = shreg_q[0];
            hold_data_d      = 1'b0;
            st_d             = ST_HOLD;
          end else begin
            st_d = ST_IDLE;  // Not ours, stay off the bus
          end
        end
      end
      ST_HOLD: begin
        if (resume) begin
          ack_send_d = ack_eff;
          cnt_d      = `I2CTS_CNT_ZERO;
          if (finish_transfer) begin
            aft_d = AFT_IDLE;
            st_d  = dir_q ? ST_IDLE : ST_ACK_OUT;
          end else if (!hold_data_q) begin
            aft_d = dir_q ? AFT_DIF : AFT_RX;
            st_d  = ST_ACK_OUT;
          end else if (!dir_q) begin
            aft_d = AFT_RX;
            st_d  = ST_ACK_OUT;
          end else begin
            st_d  = ST_TX;
          end
        end
      end
      ST_ACK_OUT: begin
        if (scl_rise) begin
          cnt_d = `I2CTS_CNT_ONE;
          if (ack_send_q && !sda_now) begin
            tx_clash_d  = 1'b1;
            clash_act_d = 1'b1;
          end
        end else if (scl_fall && cnt_q != `I2CTS_CNT_ZERO) begin
          cnt_d = `I2CTS_CNT_ZERO;
          case (aft_q)
            AFT_RX:  st_d = ST_RX;
            AFT_DIF: begin
              data_flag_d = 1'b1;
              hold_data_d = 1'b1;
              st_d        = ST_HOLD;
            end
            default: st_d = ST_IDLE;
          endcase
        end
      end
      ST_RX: begin
        if (scl_rise) begin
          shreg_d = {shreg_q[6:0], sda_now};
          cnt_d   = cnt_q + `I2CTS_CNT_ONE;
        end else if (scl_fall && cnt_q == `I2CTS_BYTE_BITS) begin
          cnt_d       = `I2CTS_CNT_ZERO;
          data_flag_d = 1'b1;
          hold_data_d = 1'b1;
          st_d        = ST_HOLD;
        end
      end
      ST_TX: begin
        if (scl_rise) begin
          cnt_d = cnt_q + `I2CTS_CNT_ONE;
          if (shreg_q[7] && !sda_now) begin
            tx_clash_d  = 1'b1;
            clash_act_d = 1'b1;
          end
        end else if (scl_fall) begin
          if (cnt_q == `I2CTS_BYTE_BITS) begin
            cnt_d = `I2CTS_CNT_ZERO;
            st_d  = ST_ACK_IN;
          end else begin
            shreg_d = {shreg_q[6:0], 1'b1};  // Fill with released bits
          end
        end
      end
      ST_ACK_IN: begin
        if (scl_rise) begin
          received_ack_bit_d = sda_now;
          cnt_d              = `I2CTS_CNT_ONE;
        end else if (scl_fall && cnt_q != `I2CTS_CNT_ZERO) begin
          cnt_d       = `I2CTS_CNT_ZERO;
          data_flag_d = 1'b1;
          hold_data_d = 1'b1;
          st_d        = ST_HOLD;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // Start or Stop past a byte's first bit clock, or Stop right after Start
    if (((bus_start | bus_stop) & in_byte & (cnt_q > `I2CTS_CNT_ONE)) |
        (bus_stop & start_seen_q)) begin
      bus_fault_d = 1'b1;
    end
    // Bus conditions override the byte sequence
    if (bus_start) begin
      st_d         = ST_ADDR;
      cnt_d        = `I2CTS_CNT_ZERO;
      clash_act_d  = 1'b0;
      start_seen_d = 1'b1;
    end else if (bus_stop) begin
      if (stop_flag_en && st_q != ST_IDLE) begin
        addr_stop_flag_d = 1'b1;
        cause_select_d   = 1'b0;
      end
      st_d        = ST_IDLE;
      cnt_d       = `I2CTS_CNT_ZERO;
      clash_act_d = 1'b0;
    end
    // Disabled port stays released and idle
    if (!port_en) begin
      st_d  = ST_IDLE;
      cnt_d = `I2CTS_CNT_ZERO;
    end
  end

  // ----------------------------------------
  // Stored command-register bit
  // ----------------------------------------
  always @* begin
    ack_choice_d = ack_choice_q;
    // A reserved code drops the whole write, choice bit included
    if (cmd_wr && !cmd_rsvd) begin
      ack_choice_d = reg_wdata[`I2CTS_CB_ACK];
    end
  end

  // ----------------------------------------
  // Read data mux, valid only the cycle after the strobe
  // ----------------------------------------
  always @* begin
    rdata_d = `I2CTS_RST_BYTE;
    if (!reg_rd) begin
      rdata_d = `I2CTS_RST_BYTE;
    end else if (sel(reg_addr, `I2CTS_OFS_SETUP_A)) begin
      rdata_d = setup_q;
    end else if (sel(reg_addr, `I2CTS_OFS_COMMAND)) begin
      rdata_d = {5'h00, ack_choice_q, `I2CTS_CMD_IDLE};
    end else if (sel(reg_addr, `I2CTS_OFS_FLAGS)) begin
      rdata_d = {data_flag_q, addr_stop_flag_q, in_hold, received_ack_bit_q,
                 tx_clash_q, bus_fault_q, dir_q, cause_select_q};
    end else if (sel(reg_addr, `I2CTS_OFS_OWN)) begin
      rdata_d = own_q;
    end else if (sel(reg_addr, `I2CTS_OFS_DATA)) begin
      rdata_d = shreg_q;
    end else begin
      rdata_d = `I2CTS_RST_BYTE;  // Unmapped reads zero
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q           <= 2'h3;
      pin_s2_q           <= 2'h3;
      pin_s3_q           <= 2'h3;
      filt_q             <= 2'h3;  // Idle bus reads high
      setup_q            <= `I2CTS_RST_BYTE;
      own_q              <= `I2CTS_RST_BYTE;
      ack_choice_q       <= 1'b0;
      st_q               <= ST_IDLE;
      aft_q              <= AFT_RX;
      cnt_q              <= `I2CTS_CNT_ZERO;
      shreg_q            <= `I2CTS_RST_BYTE;
      hold_data_q        <= 1'b0;
      ack_send_q         <= 1'b0;
      data_flag_q        <= 1'b0;
      addr_stop_flag_q   <= 1'b0;
      received_ack_bit_q <= 1'b0;
      tx_clash_q         <= 1'b0;
      clash_act_q        <= 1'b0;
      bus_fault_q        <= 1'b0;
      dir_q              <= 1'b0;
      cause_select_q     <= 1'b0;
      start_seen_q       <= 1'b0;
      reg_rdata_q        <= `I2CTS_RST_BYTE;
      scl_out_q          <= 1'b0;
      scl_oe_q           <= 1'b0;
      sda_out_q          <= 1'b0;
      sda_oe_q           <= 1'b0;
      data_irq_q         <= 1'b0;
      addr_stop_irq_q    <= 1'b0;
    end else begin
      pin_s1_q           <= {sda_in, scl_in};
      pin_s2_q           <= pin_s1_q;
      pin_s3_q           <= pin_s2_q;
      filt_q             <= filt_d;
      if (reg_wr && sel(reg_addr, `I2CTS_OFS_SETUP_A)) begin
        setup_q <= reg_wdata & `I2CTS_SA_MASK;
      end
      if (reg_wr && sel(reg_addr, `I2CTS_OFS_OWN)) begin
        own_q <= reg_wdata;
      end
      ack_choice_q       <= ack_choice_d;
      st_q               <= st_d;
      aft_q              <= aft_d;
      cnt_q              <= cnt_d;
      shreg_q            <= shreg_d;
      hold_data_q        <= hold_data_d;
      ack_send_q         <= ack_send_d;
      data_flag_q        <= data_flag_d;
      addr_stop_flag_q   <= addr_stop_flag_d;
      received_ack_bit_q <= received_ack_bit_d;
      tx_clash_q         <= tx_clash_d;
      clash_act_q        <= clash_act_d;
      bus_fault_q        <= bus_fault_d;
      dir_q              <= dir_d;
      cause_select_q     <= cause_select_d;
      start_seen_q       <= start_seen_d;
      reg_rdata_q        <= rdata_d;
      // Open drain: only ever pull low
      scl_out_q          <= 1'b0;
      sda_out_q          <= 1'b0;
      scl_oe_q           <= (st_d == ST_HOLD);
      // After a clash no low value reaches SDA
      sda_oe_q           <= ~clash_act_d &
                            (((st_d == ST_ACK_OUT) & ~ack_send_d) |
                             ((st_d == ST_TX) & ~shreg_d[7]));
      data_irq_q         <= data_irq_en & data_flag_q & global_irq_en;
      addr_stop_irq_q    <= addr_stop_irq_en & addr_stop_flag_q & stop_flag_en & global_irq_en;
    end
  end

endmodule

`default_nettype wire

// ---- logic/i2cts_consts.vh ----
// Constants for the I2C target control and status block
// What this block does
// - Data interrupt needs enable, flag, global enable
// - Address/stop interrupt also needs stop enable
// - Stop sets address/stop flag when enabled and sequencer not idle
// - Promiscuous bit accepts every received address
// - Auto continue resumes on data access
// - Target port works only while enabled
// - Acknowledge choice zero sends ACK, one NACK
// - Acknowledge choice is a plain stored bit
// - Command field is strobe reading zero
// - Finish command acknowledges a write, releases a read, then awaits Start
// - Respond after address: ack, then receive/flag
// - Respond after data: receive or transmit byte
// - Acknowledge choice and command written together
// - Data flag set on byte or acknowledge done, not on clash; set after a clashed byte's acknowledge too
// - Data flag cleared by write, access, command
// - Address/stop flag set on match or Stop
// - Address-match or data flag set holds SCL low, reported; Stop flag does not
// - Last master acknowledge bit captured, read-only
// - Clash sets flag, stops low drive
// - Clash flag cleared by write or Start
// - Cause bit: zero Stop, one address
// - Direction bit follows last matched address R/W bit
// - Misplaced Start or Stop sets bus fault
`ifndef I2CTS_CONSTS_VH
`define I2CTS_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define I2CTS_OFS_SETUP_A   8'h09
`define I2CTS_OFS_COMMAND   8'h0A
`define I2CTS_OFS_FLAGS     8'h0B
`define I2CTS_OFS_OWN       8'h0C
`define I2CTS_OFS_DATA      8'h0D

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define I2CTS_SA_DATA_IRQ_EN       7
`define I2CTS_SA_ADDR_STOP_IRQ_EN      6
`define I2CTS_SA_STOP_FLAG_EN       5
`define I2CTS_SA_PROMISCUOUS_MATCH       2
`define I2CTS_SA_AUTO_CONTINUE_EN       1
`define I2CTS_SA_EN         0
`define I2CTS_SA_MASK       8'hE7
`define I2CTS_CB_ACK        2
`define I2CTS_FL_DIF        7
`define I2CTS_FL_ADDR_STOP_FLAG       6
`define I2CTS_FL_TX_CLASH       3
`define I2CTS_FL_BERR       2

// ----------------------------------------
// Command codes
// ----------------------------------------
`define I2CTS_CMD_IDLE      2'h0
`define I2CTS_CMD_RSVD      2'h1
`define I2CTS_CMD_FINISH    2'h2
`define I2CTS_CMD_RESPOND   2'h3

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define I2CTS_RST_BYTE      8'h00
`define I2CTS_CNT_ZERO      4'h0
`define I2CTS_CNT_ONE       4'h1
`define I2CTS_BYTE_BITS     4'h8
`define I2CTS_GCALL_ADDR    7'h00

`endif

// ---- sim/i2cts_top_assertions.sv ----
// Port-level concurrent checks for the I2C target block
`timescale 1ns/1ps
`default_nettype none
module i2cts_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       global_irq_en,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       scl_out_q,
  input wire logic       scl_oe_q,
  input wire logic       sda_out_q,
  input wire logic       sda_oe_q,
  input wire logic       data_irq_q,
  input wire logic       addr_stop_irq_q
);
  // ----
  // Shadow state rebuilt from the register strobes
  // ----
  logic       ack_q;   // Ack choice as software last set it
  logic       en_q;    // Port enable as software last set it
  logic [2:0] quiet_q; // Idle cycles since last access, saturating
  wire        cmd_wr = reg_wr && reg_addr == 8'h0A;
  wire        cmd_rd = reg_rd && reg_addr == 8'h0A;
  // Reserved code drops the whole write, so ack is kept then
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      en_q <= 1'b0;
      quiet_q <= 3'h0;
    end else begin
      if (cmd_wr && reg_wdata[1:0] != 2'h1) begin
        ack_q <= reg_wdata[2];
      end
      if (reg_wr && reg_addr == 8'h09) begin
        en_q <= reg_wdata[0];
      end
      if (reg_wr || reg_rd) begin
        quiet_q <= 3'h0;
      end else if (quiet_q != 3'h7) begin
        quiet_q <= quiet_q + 3'h1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_data_irq_gate: assert property (data_irq_q |-> $past(global_irq_en))
    else $error("data irq without global enable");
  a_as_irq_gate: assert property (addr_stop_irq_q |-> $past(global_irq_en))
    else $error("addr stop irq without global enable");
  a_cmd_readback: assert property ($past(cmd_rd) |-> reg_rdata_q == {5'h00, $past(ack_q), 2'h0})
    else $error("command register read back wrong");
  a_disabled_quiet: assert property (!en_q [*3] |-> !scl_oe_q && !sda_oe_q)
    else $error("disabled port drives the bus");
  a_hold_on_low: assert property ($rose(scl_oe_q) |-> !$past(scl_in))
    else $error("clock hold started while SCL high");
  a_sda_on_low: assert property ($changed(sda_oe_q) |-> !$past(scl_in, 3))
    else $error("SDA drive changed while SCL high");
  a_hold_steady: assert property (scl_oe_q && quiet_q == 3'h7 |=> scl_oe_q)
    else $error("clock hold dropped without software");
  a_reserved_hold: assert property (scl_oe_q && cmd_wr && reg_wdata[1:0] == 2'h1 |=> scl_oe_q [*3])
    else $error("reserved command released the clock");
  a_resume_release: assert property (scl_oe_q && cmd_wr && reg_wdata[1] |-> ##[1:4] !scl_oe_q)
    else $error("command did not release the clock");
  c_hold: cover property ($rose(scl_oe_q));
  c_data_irq: cover property ($rose(data_irq_q));
  c_as_irq: cover property ($rose(addr_stop_irq_q));
endmodule
bind i2cts_top i2cts_chk u_chk (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .global_irq_en(global_irq_en), .scl_in(scl_in),
  .sda_in(sda_in), .scl_out_q(scl_out_q), .scl_oe_q(scl_oe_q), .sda_out_q(sda_out_q),
  .sda_oe_q(sda_oe_q), .data_irq_q(data_irq_q), .addr_stop_irq_q(addr_stop_irq_q));
`default_nettype wire

// ---- sim/i2cts_master_model.sv ----
// Behavioural I2C bus controller with pull-ups on both lines
`timescale 1ns/1ps
`default_nettype none
module i2cts_master_model (
  input  wire logic scl_out_q,
  input  wire logic scl_oe_q,
  input  wire logic sda_out_q,
  input  wire logic sda_oe_q,
  output var  logic scl_in,
  output var  logic sda_in
);
  logic scl_lo = 1'b0; // Controller pulls SCL low
  logic sda_lo = 1'b0; // Controller pulls SDA low
  // Wired-AND: a line nobody pulls floats high, never a stale value
  always_comb begin
    scl_in = !(scl_lo || (scl_oe_q && !scl_out_q));
    sda_in = !(sda_lo || (sda_oe_q && !sda_out_q));
  end
  // Release SCL; bounded wait so a stuck stretch cannot hang us
  task automatic rise();
    int n;
    scl_lo = 1'b0;
    for (n = 0; n < 8000 && !scl_in; n++) begin
      #5;
    end
  endtask
  // One bit: SDA set in the low phase, sampled mid high phase
  task automatic bit_slot(input logic b, output logic r);
    sda_lo = !b;
    #20;
    rise();
    #20;
    r = sda_in;
    #20;
    scl_lo = 1'b1;
    #20;
  endtask
  // Start from idle or as a repeated Start
  task automatic start();
    sda_lo = 1'b0;
    #20;
    rise();
    #20;
    sda_lo = 1'b1;
    #40;
    scl_lo = 1'b1;
    #20;
  endtask
  task automatic stop();
    sda_lo = 1'b1;
    #20;
    rise();
    #40;
    sda_lo = 1'b0;
    #40;
  endtask
  // Eight bits MSB first, then an acknowledge slot left released
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    int i;
    for (i = 7; i >= 0; i--) begin
      bit_slot(tx[i], rx[i]);
    end
    bit_slot(1'b1, ack);
  endtask
endmodule
`default_nettype wire

// ---- sim/i2cts_top_test.sv ----
// Self-checking bench for the I2C target control and status block
`timescale 1ns/1ps
`default_nettype none
module i2cts_top_test;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       global_irq_en = 1'b1;
  logic [7:0] reg_rdata_q, rxb;
  logic       ackb, scl_in, sda_in, scl_out_q, scl_oe_q, sda_out_q, sda_oe_q, data_irq_q, addr_stop_irq_q;
  int         failures = 0;
  int         compares = 0;
  initial forever #2.5 clk = ~clk;
  i2cts_top DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .global_irq_en(global_irq_en),
    .scl_in(scl_in), .sda_in(sda_in), .scl_out_q(scl_out_q), .scl_oe_q(scl_oe_q), .sda_out_q(sda_out_q),
    .sda_oe_q(sda_oe_q), .data_irq_q(data_irq_q), .addr_stop_irq_q(addr_stop_irq_q));
  i2cts_master_model mst (.scl_out_q(scl_out_q), .scl_oe_q(scl_oe_q), .sda_out_q(sda_out_q),
    .sda_oe_q(sda_oe_q), .scl_in(scl_in), .sda_in(sda_in));
  // ----
  // Shared tasks
  // ----
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, e, reg_rdata_q & m);
  endtask
  task automatic wait_hold();
    int n;
    for (n = 0; n < 4000 && scl_oe_q !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("scl hold", 8'h01, {7'h00, scl_oe_q});
  endtask
  // Byte on the bus while software serves the stretch, then resumes
  task automatic step(input logic [7:0] tx, input logic [7:0] fm, input logic [7:0] fe,
      input logic [7:0] a, input logic [7:0] d, input logic isrd);
    fork
      mst.xfer(tx, rxb, ackb);
      begin
        wait_hold();
        rd(8'h0B, fm, fe, "flags");
        chk("irqs", {6'h00, fe[7:6]} & {8{global_irq_en}}, {6'h00, data_irq_q, addr_stop_irq_q});
        wr(8'h0A, 8'h01);
        repeat (3) @(posedge clk);
        #1 chk("held", 8'h01, {7'h00, scl_oe_q});
        if (isrd) rd(a, 8'hFF, d, "data");
        else wr(a, d);
      end
    join
  endtask
  // Stop while held after a sent byte; check flags, then finish
  task automatic finish(input logic [7:0] m, input logic [7:0] e);
    fork
      mst.stop();
      begin
        wait_hold();
        rd(8'h0B, m, e, "end flags");
        wr(8'h0A, 8'h02);
      end
    join
    wr(8'h0B, 8'hC0);
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h09, 8'hFF, 8'h00, "setup rst");
    rd(8'h0B, 8'hFF, 8'h00, "flags rst");
    rd(8'h20, 8'hFF, 8'h00, "unmapped");
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'hFF, 8'hE7, "setup");
    wr(8'h0A, 8'h04);
    rd(8'h0A, 8'hFF, 8'h04, "ack");
    wr(8'h0A, 8'h01);
    rd(8'h0A, 8'hFF, 8'h04, "rsvd");
    wr(8'h09, 8'hE2);
    wr(8'h0A, 8'h00);
    wr(8'h0C, 8'hA0);
    mst.start();
    mst.xfer(8'hA0, rxb, ackb);
    chk("off ack", 8'h01, {7'h00, ackb});
    mst.stop();
    // Controller writes one byte, software auto-continues
    wr(8'h09, 8'hE3);
    mst.start();
    step(8'hA0, 8'hFF, 8'h61, 8'h0A, 8'h03, 1'b0);
    chk("addr ack", 8'h00, {7'h00, ackb});
    step(8'h3C, 8'hF2, 8'hA0, 8'h0D, 8'h3C, 1'b1);
    chk("data ack", 8'h00, {7'h00, ackb});
    mst.stop();
    repeat (4) @(posedge clk);
    rd(8'h0B, 8'hFF, 8'h40, "stop");
    wr(8'h0B, 8'h40);
    rd(8'h0B, 8'hFF, 8'h00, "w1c");
    // Masked interrupts, NACK chosen with the command
    @(posedge clk) global_irq_en <= 1'b0;
    mst.start();
    step(8'hA0, 8'hFF, 8'h61, 8'h0A, 8'h03, 1'b0);
    step(8'hC3, 8'hF2, 8'hA0, 8'h0A, 8'h07, 1'b0);
    chk("nack", 8'h01, {7'h00, ackb});
    rd(8'h0A, 8'hFF, 8'h04, "ack kept");
    mst.stop();
    wr(8'h0B, 8'hC0);
    wr(8'h0A, 8'h00);
    @(posedge clk) global_irq_en <= 1'b1;
    // Controller reads a byte, then a read that collides
    mst.start();
    step(8'hA1, 8'hFF, 8'h63, 8'h0A, 8'h03, 1'b0);
    step(8'hFF, 8'hE2, 8'hA2, 8'h0D, 8'h96, 1'b0);
    chk("tx byte", 8'h96, rxb);
    finish(8'hF2, 8'hB2);
    mst.start();
    step(8'hA1, 8'hFF, 8'h73, 8'h0A, 8'h03, 1'b0);
    step(8'h7F, 8'hE2, 8'hA2, 8'h0D, 8'hAA, 1'b0);
    chk("clash tx", 8'h7F, rxb);
    finish(8'hC8, 8'h88);
    mst.start();
    repeat (6) @(posedge clk);
    rd(8'h0B, 8'h08, 8'h00, "clash clr");
    mst.xfer(8'h40, rxb, ackb);
    chk("mismatch", 8'h01, {7'h00, ackb});
    mst.stop();
    // Any address accepted, finished with an ACK
    wr(8'h09, 8'hE7);
    mst.start();
    step(8'h40, 8'hFF, 8'h71, 8'h0A, 8'h02, 1'b0);
    chk("any ack", 8'h00, {7'h00, ackb});
    mst.stop();
    wr(8'h0B, 8'hC0);
    // Start directly followed by Stop
    mst.sda_lo = 1'b1;
    #80 mst.sda_lo = 1'b0;
    #80;
    rd(8'h0B, 8'h04, 8'h04, "bus fault");
    conclude();
  end
  // Hang guard, well past the expected run time
  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
